/* File: pkg/ssm_params.svh */
// Purpose: constants of the synchronous serial port block
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes:   definitions only
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH

// register byte offsets
`define SSM_OFF_BAUDCTL   12'h000
`define SSM_OFF_RXSTAT    12'h004
`define SSM_OFF_DIVLO     12'h008
`define SSM_OFF_DIVHI     12'h00c
`define SSM_OFF_TXDATA    12'h010
`define SSM_OFF_TXSTAT    12'h014
`define SSM_OFF_RXDATA    12'h018
`define SSM_OFF_INTCTL    12'h01c

// baud_and_clock_control fields
`define SSM_B_POL         4
`define SSM_B_WIDE        3
// receive_status_control fields
`define SSM_B_SERIAL_PORT_ENABLE        7
`define SSM_B_RX9         6
`define SSM_B_SINGLE_RECEIVE_ENABLE        5
`define SSM_B_CONTINUOUS_RECEIVE_ENABLE        4
`define SSM_B_OVERRUN_ERROR_FLAG        1
`define SSM_B_RECEIVE_NINTH_BIT        0
// transmit_status_control fields
`define SSM_B_CLOCK_SOURCE_MASTER_SELECT        7
`define SSM_B_TX9         6
`define SSM_B_TRANSMIT_ENABLE        5
`define SSM_B_SYNC        4
`define SSM_B_HIGH_SPEED_BAUD_SELECT        2
`define SSM_B_TRMT        1
`define SSM_B_TRANSMIT_NINTH_BIT        0
// interrupt control fields
`define SSM_B_RECEIVE_INTERRUPT_ENABLE        0
`define SSM_B_TRANSMIT_INTERRUPT_ENABLE        1
`define SSM_B_RECEIVE_INTERRUPT_FLAG        2
`define SSM_B_TXIF        3

// reset value of every writable register
`define SSM_RST_BYTE      8'h00
// last bit index of a character
`define SSM_LAST8         4'h7
`define SSM_LAST9         4'h8
// receive fifo depth in characters
`define SSM_FIFO_FULL     2'h2

`endif

/* File: pkg/ssm_pkg.sv */
// Purpose: types shared by the synchronous serial port block
// Assumes: used with ssm_params.svh
// Notes:   one-hot engine states
package ssm_pkg;

   typedef enum logic [2:0] {
      SSM_IDLE = 3'b001,
      SSM_TX   = 3'b010,
      SSM_RX   = 3'b100
   } ssm_state_e;

   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } ssm_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ssm_apb_rsp_s;

endpackage

/* File: src/ssm_top.sv */
// Purpose: synchronous half-duplex serial port, master or slave, with APB registers
// Assumes: sys_clk 125 MHz; link pins sampled through two flip-flops
// Notes:   output enables are active low (low = driving)
//
// The implementer's own choices: the address map and the APB slave port.
`include "ssm_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ssm_top (
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   input  wire ssm_pkg::ssm_apb_req_s apb_req,
   output var  ssm_pkg::ssm_apb_rsp_s apb_rsp,
   input  wire logic                 data_pin_in,
   output logic                      data_pin_out,
   output logic                      data_pin_oe_n,
   input  wire logic                 shift_clock_pin_in,
   output logic                      shift_clock_pin_out,
   output logic                      shift_clock_pin_oe_n,
   output logic                      rx_irq
);
   import ssm_pkg::*;

   // address match, used for every register
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   // software registers
   logic [7:0]  baudctl_reg;
   logic [7:0]  divlo_reg;
   logic [7:0]  divhi_reg;
   logic [7:0]  txctl_reg;
   logic        serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg;
   logic        receive_interrupt_enable_reg, transmit_interrupt_enable_reg;
   // engine state
   ssm_state_e  st_reg;
   logic [17:0] bcnt_reg;
   logic        half_reg;
   logic [3:0]  bit_reg;
   logic [8:0]  tsr_reg;
   logic [8:0]  rsr_reg;
   logic [8:0]  txbuf_reg;
   logic        txfull_reg;
   logic [8:0]  fifo_mem [2];
   logic        rdp_reg;
   logic [1:0]  cnt_reg;
   logic        overrun_error_flag_reg, ovr_cont_reg;
   logic        ck_prev_reg;
   logic [1:0]  s1_reg, s2_reg;
   ssm_apb_rsp_s rsp_reg;
   logic        dto_reg, dtoe_reg, cko_reg, ckoe_reg, irq_reg;

   // two-flop synchronisers: bit 0 data pin, bit 1 clock pin
   logic [1:0] pin_raw;
   assign pin_raw = {shift_clock_pin_in, data_pin_in};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (!rstn) begin
               s1_reg[gi] <= 1'b0;
               s2_reg[gi] <= 1'b0;
            end else begin
               s1_reg[gi] <= pin_raw[gi];
               s2_reg[gi] <= s1_reg[gi];
            end
         end
      end
   endgenerate

   // configuration decode
   wire pol      = baudctl_reg[`SSM_B_POL];
   wire wide     = baudctl_reg[`SSM_B_WIDE];
   wire master   = txctl_reg[`SSM_B_CLOCK_SOURCE_MASTER_SELECT];
   wire tx9      = txctl_reg[`SSM_B_TX9];
   wire transmit_enable     = txctl_reg[`SSM_B_TRANSMIT_ENABLE];
   wire sync_on  = txctl_reg[`SSM_B_SYNC];
   wire high_speed_baud_select     = txctl_reg[`SSM_B_HIGH_SPEED_BAUD_SELECT];
   wire transmit_ninth_bit     = txctl_reg[`SSM_B_TRANSMIT_NINTH_BIT];
   wire rx_mode  = single_receive_enable_reg | continuous_receive_enable_reg;
   wire port_on  = serial_port_enable_reg & sync_on;
   wire [3:0] last_bit = (st_reg == SSM_RX ? rx9_reg : tx9) ? `SSM_LAST9 : `SSM_LAST8;

   // baud: half period of (div+1) clocks, times four when low speed
   wire [15:0] div      = wide ? {divhi_reg, divlo_reg} : {8'h00, divlo_reg};
   wire [17:0] half_lim = high_speed_baud_select ? {2'b00, div} : {div, 2'b11};
   wire        active   = (st_reg != SSM_IDLE);
   wire        tick     = master & active & (bcnt_reg == half_lim);

   // leading and trailing edges from own divider or remote clock
   wire ck_s    = s2_reg[1];
   wire lead_ev = master ? (tick & ~half_reg)
                         : (ck_prev_reg == pol) & (ck_s != pol);
   wire trail_ev = master ? (tick & half_reg)
                          : (ck_prev_reg != pol) & (ck_s == pol);
   wire char_end = trail_ev & (bit_reg == last_bit);

   // apb decode; the access completes when pready is high
   wire        acc     = apb_req.psel & apb_req.penable;
   wire        done_ap = acc & rsp_reg.pready;
   wire        wr      = done_ap & apb_req.pwrite;
   wire        rd      = done_ap & ~apb_req.pwrite;
   wire [11:0] a       = apb_req.paddr;
   wire [7:0]  wd      = apb_req.pwdata[7:0];
   wire        w_baud  = wr & hit(a, `SSM_OFF_BAUDCTL);
   wire        w_rxst  = wr & hit(a, `SSM_OFF_RXSTAT);
   wire        w_dlo   = wr & hit(a, `SSM_OFF_DIVLO);
   wire        w_dhi   = wr & hit(a, `SSM_OFF_DIVHI);
   wire        w_txd   = wr & hit(a, `SSM_OFF_TXDATA);
   wire        w_txst  = wr & hit(a, `SSM_OFF_TXSTAT);
   wire        w_int   = wr & hit(a, `SSM_OFF_INTCTL);
   wire        mapped  = hit(a, `SSM_OFF_BAUDCTL) | hit(a, `SSM_OFF_RXSTAT)
                       | hit(a, `SSM_OFF_DIVLO)   | hit(a, `SSM_OFF_DIVHI)
                       | hit(a, `SSM_OFF_TXDATA)  | hit(a, `SSM_OFF_TXSTAT)
                       | hit(a, `SSM_OFF_RXDATA)  | hit(a, `SSM_OFF_INTCTL);

   // receive fifo view
   wire        receive_interrupt_flag    = (cnt_reg != 2'h0);
   wire [8:0]  head    = receive_interrupt_flag ? fifo_mem[rdp_reg] : 9'h000;  // empty fifo reads zero
   wire        rd_pop  = rd & hit(a, `SSM_OFF_RXDATA) & receive_interrupt_flag;
   wire        full    = (cnt_reg == `SSM_FIFO_FULL);
   wire        rx_stop = (st_reg == SSM_RX) & (master ? ~rx_mode : ~continuous_receive_enable_reg);
   wire        rx_done = (st_reg == SSM_RX) & char_end & ~rx_stop;
   // final bit is sampled on the pushing edge, so it is merged into the word here
   wire [8:0]  rx_word = rsr_reg | (9'(s2_reg[0]) << last_bit);
   wire        push    = rx_done & (~full | rd_pop);
   wire        ovf     = rx_done & full & ~rd_pop;
   wire        trmt    = (st_reg != SSM_TX);

   // start and stop conditions
   wire rx_go   = (st_reg == SSM_IDLE) & port_on & ~overrun_error_flag_reg
                & (master ? rx_mode : continuous_receive_enable_reg);
   wire tx_go   = (st_reg == SSM_IDLE) & port_on & transmit_enable & ~rx_mode
                & txfull_reg;

   // read data mux
   wire [7:0] rxst_rd = {serial_port_enable_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg, 2'b00, overrun_error_flag_reg, head[8]};
   wire [7:0] txst_rd = {txctl_reg[7:3], txctl_reg[`SSM_B_HIGH_SPEED_BAUD_SELECT], trmt, txctl_reg[0]};
   wire [7:0] int_rd  = {4'h0, ~txfull_reg, receive_interrupt_flag, transmit_interrupt_enable_reg, receive_interrupt_enable_reg};
   wire [7:0] rd_byte =
        hit(a, `SSM_OFF_BAUDCTL) ? baudctl_reg :
        hit(a, `SSM_OFF_RXSTAT)  ? rxst_rd     :
        hit(a, `SSM_OFF_DIVLO)   ? divlo_reg   :
        hit(a, `SSM_OFF_DIVHI)   ? divhi_reg   :
        hit(a, `SSM_OFF_TXSTAT)  ? txst_rd     :
        hit(a, `SSM_OFF_RXDATA)  ? head[7:0]   :
        hit(a, `SSM_OFF_INTCTL)  ? int_rd      : 8'h00;

   // apb answer: one wait state, registered response
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg.pready  <= acc & ~rsp_reg.pready;
         rsp_reg.prdata  <= {24'h000000, rd_byte};
         rsp_reg.pslverr <= acc & ~rsp_reg.pready & ~mapped;
      end
   end

   // plain configuration registers
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         baudctl_reg <= `SSM_RST_BYTE;
         divlo_reg   <= `SSM_RST_BYTE;
         divhi_reg   <= `SSM_RST_BYTE;
         txctl_reg   <= `SSM_RST_BYTE;
         receive_interrupt_enable_reg    <= 1'b0;
         transmit_interrupt_enable_reg    <= 1'b0;
      end else begin
         if (w_baud) baudctl_reg <= wd & 8'h18;
         if (w_dlo)  divlo_reg   <= wd;
         if (w_dhi)  divhi_reg   <= wd;
         if (w_txst) txctl_reg   <= wd & 8'hf5;       // status bit not stored
         if (w_int) begin
            receive_interrupt_enable_reg <= wd[`SSM_B_RECEIVE_INTERRUPT_ENABLE];
            transmit_interrupt_enable_reg <= wd[`SSM_B_TRANSMIT_INTERRUPT_ENABLE];
         end
      end
   end

   // receive control; software write after hardware clear so a write wins
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         serial_port_enable_reg <= 1'b0;
         rx9_reg  <= 1'b0;
         single_receive_enable_reg <= 1'b0;
         continuous_receive_enable_reg <= 1'b0;
      end else begin
         if (rx_done & master) single_receive_enable_reg <= 1'b0;
         if (w_rxst) begin
            serial_port_enable_reg <= wd[`SSM_B_SERIAL_PORT_ENABLE];
            rx9_reg  <= wd[`SSM_B_RX9];
            single_receive_enable_reg <= wd[`SSM_B_SINGLE_RECEIVE_ENABLE];
            continuous_receive_enable_reg <= wd[`SSM_B_CONTINUOUS_RECEIVE_ENABLE];
         end
      end
   end

   // overrun flag: set wins over every clear
   wire overrun_error_flag_clr = (rd_pop & ~ovr_cont_reg) | (ovr_cont_reg & ~continuous_receive_enable_reg) | ~serial_port_enable_reg;
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         overrun_error_flag_reg     <= 1'b0;
         ovr_cont_reg <= 1'b0;
      end else if (ovf) begin
         overrun_error_flag_reg     <= 1'b1;
         ovr_cont_reg <= continuous_receive_enable_reg;
      end else if (overrun_error_flag_clr) begin
         overrun_error_flag_reg     <= 1'b0;
      end
   end

   // two-character fifo; disabling the port empties it
   always_ff @(posedge sys_clk) begin
      if (!rstn || !serial_port_enable_reg) begin
         rdp_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         if (push) fifo_mem[rdp_reg ^ cnt_reg[0]] <= rx_word;
         if (rd_pop) rdp_reg <= ~rdp_reg;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, rd_pop};
      end
   end

   // transmit holding register; ninth bit captured with the data
   always_ff @(posedge sys_clk) begin
      if (!rstn || !serial_port_enable_reg) begin
         txfull_reg <= 1'b0;
         txbuf_reg  <= 9'h000;
      end else if (w_txd) begin
         txfull_reg <= 1'b1;
         txbuf_reg  <= {transmit_ninth_bit, wd};
      end else if (tx_go) begin
         txfull_reg <= 1'b0;
      end
   end

   // baud counter and half-cycle phase; idle keeps the phase at zero
   always_ff @(posedge sys_clk) begin
      if (!rstn || !active || !master) begin
         bcnt_reg <= 18'h00000;
         half_reg <= 1'b0;
      end else if (tick) begin
         bcnt_reg <= 18'h00000;
         half_reg <= ~half_reg;
      end else begin
         bcnt_reg <= bcnt_reg + 18'h00001;
      end
   end

   // character engine
   always_ff @(posedge sys_clk) begin
      if (!rstn || !serial_port_enable_reg) begin
         st_reg  <= SSM_IDLE;
         bit_reg <= 4'h0;
         tsr_reg <= 9'h000;
         rsr_reg <= 9'h000;
      end else begin
         case (st_reg)
            SSM_IDLE: begin
               bit_reg <= 4'h0;
               rsr_reg <= 9'h000;
               if (rx_go) begin
                  st_reg <= SSM_RX;
               end else if (tx_go) begin
                  st_reg  <= SSM_TX;
                  tsr_reg <= txbuf_reg;
               end
            end
            SSM_TX: begin
               if (trail_ev) begin
                  tsr_reg <= {1'b0, tsr_reg[8:1]};
                  bit_reg <= bit_reg + 4'h1;
               end
               if (char_end) st_reg <= SSM_IDLE;
            end
            SSM_RX: begin
               if (rx_stop) begin
                  st_reg <= SSM_IDLE;
               end else if (char_end) begin
                  rsr_reg <= 9'h000;
                  bit_reg <= 4'h0;
                  if (!continuous_receive_enable_reg || ovf) st_reg <= SSM_IDLE;
               end else if (trail_ev) begin
                  rsr_reg[bit_reg] <= s2_reg[0];
                  bit_reg <= bit_reg + 4'h1;
               end
            end
            default: st_reg <= SSM_IDLE;
         endcase
      end
   end

   // pins and interrupt, all registered
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ck_prev_reg <= 1'b0;
         dto_reg     <= 1'b0;
         dtoe_reg    <= 1'b1;
         cko_reg     <= 1'b0;
         ckoe_reg    <= 1'b1;
         irq_reg     <= 1'b0;
      end else begin
         ck_prev_reg <= ck_s;
         dtoe_reg    <= ~(port_on & ~rx_mode & transmit_enable);
         ckoe_reg    <= ~(port_on & master);
         irq_reg     <= receive_interrupt_flag & receive_interrupt_enable_reg;
         if ((st_reg == SSM_TX) & lead_ev) dto_reg <= tsr_reg[0];
         if (master & active & lead_ev & ~rx_stop) cko_reg <= ~pol;
         else if (~active | trail_ev | rx_stop) cko_reg <= pol;
      end
   end

   assign apb_rsp              = rsp_reg;
   assign data_pin_out         = dto_reg;
   assign data_pin_oe_n        = dtoe_reg;
   assign shift_clock_pin_out  = cko_reg;
   assign shift_clock_pin_oe_n = ckoe_reg;
   assign rx_irq               = irq_reg;

   // checks next to the logic they guard
   a_dt_released: assert property (@(posedge sys_clk) disable iff (!rstn)
      (port_on & rx_mode) |=> data_pin_oe_n)
      else $error("data driver on during receive");
   a_ck_released: assert property (@(posedge sys_clk) disable iff (!rstn)
      (serial_port_enable_reg & ~master) |=> shift_clock_pin_oe_n)
      else $error("clock driver on in slave mode");
   a_ck_idle_level: assert property (@(posedge sys_clk) disable iff (!rstn)
      (st_reg == SSM_IDLE) [*2] |=> (shift_clock_pin_out == $past(pol)))
      else $error("clock not at idle level");
   a_single_receive_enable_self_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rx_done & master & ~w_rxst) |=> !single_receive_enable_reg)
      else $error("single receive not cleared");
   a_abort_drops: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rx_stop & serial_port_enable_reg) |=> (st_reg == SSM_IDLE) && (cnt_reg == $past(cnt_reg) - $past({1'b0, rd_pop})))
      else $error("aborted character not dropped");
   a_overrun_keeps: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ovf & serial_port_enable_reg) |=> overrun_error_flag_reg && (cnt_reg == `SSM_FIFO_FULL))
      else $error("overrun lost or overwrote data");
   a_overrun_blocks: assert property (@(posedge sys_clk) disable iff (!rstn)
      (overrun_error_flag_reg && st_reg == SSM_IDLE) |=> (st_reg != SSM_RX))
      else $error("receive started under overrun");
   a_irq_gated: assert property (@(posedge sys_clk) disable iff (!rstn)
      rx_irq |-> $past(receive_interrupt_enable_reg && cnt_reg != 2'h0))
      else $error("interrupt without enable");
   a_rx_sample: assert property (@(posedge sys_clk) disable iff (!rstn)
      (st_reg == SSM_RX && trail_ev && bit_reg == 4'h0 && !rx_stop && !char_end)
      |=> rsr_reg[0] == $past(s2_reg[0]))
      else $error("bit not sampled on trailing edge");
   a_fifo_pop: assert property (@(posedge sys_clk) disable iff (!rstn || !serial_port_enable_reg)
      (rd_pop && !push) |=> cnt_reg == $past(cnt_reg) - 2'h1)
      else $error("read did not advance fifo");

endmodule

`default_nettype wire

/* File: tb/ssm_remote.sv */
// Purpose: remote synchronous serial device on the far side of the pins
// Assumes: resolved line levels, sampled with the system clock
// Notes:   leading edge leaves the idle level; lsb first
`timescale 1ns/1ps
`default_nettype none
module ssm_remote (
   input  wire logic            sys_clk,
   input  wire logic            restart,
   input  wire logic            pol,
   input  wire logic [3:0]      nbits,
   input  wire logic [3:0][8:0] tx_w,
   input  wire logic            ck_line,
   input  wire logic            dt_line,
   output logic                 dt_bit,
   output logic [3:0][8:0]      rx_w,
   output logic [7:0]           n_lead,
   output logic                 ck_drv
);
   logic       ck_q;
   logic [1:0] tc;
   logic [1:0] rc;
   logic [3:0] ti;
   logic [3:0] ri;
   wire        seen   = ck_line != ck_q;
   wire        last_t = ti == nbits - 4'h1;
   wire        last_r = ri == nbits - 4'h1;
   initial begin
      ck_drv = 1'b0;
      dt_bit = 1'b0;
   end
   // data moves on leading edges and is taken on trailing ones
   always @(posedge sys_clk) begin
      ck_q <= ck_line;
      if (restart) begin
         {tc, rc, ti, ri, n_lead, rx_w} <= '0;
      end else if (seen && ck_q == pol) begin
         dt_bit <= tx_w[tc][ti];
         n_lead <= n_lead + 8'h01;
         ti     <= last_t ? 4'h0 : ti + 4'h1;
         tc     <= tc + 2'(last_t);
      end else if (seen) begin
         rx_w[rc][ri] <= dt_line;
         ri           <= last_r ? 4'h0 : ri + 4'h1;
         rc           <= rc + 2'(last_r);
      end
   end
   // one clock per data bit, resting idle outside the frame
   task automatic clocks(input int n);
      ck_drv = pol;
      #3;
      repeat (n) begin
         #32 ck_drv = ~pol;
         #32 ck_drv = pol;
      end
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the synchronous serial port
// Assumes: remote model on the pins, APB master tasks here
// Notes:   an undriven data line toggles so stale levels never pass
`include "ssm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ssm_pkg::*;
   logic            sys_clk = 1'b0;
   logic            rstn    = 1'b0;
   ssm_apb_req_s    req     = '0;
   ssm_apb_rsp_s    rsp;
   logic            dt_out, dt_oe_n, ck_out, ck_oe_n, rx_irq, dt_bit, rem_ckv, err;
   logic            pol     = 1'b0;
   logic            rem_en  = 1'b0;
   logic            rem_ck  = 1'b0;
   logic            restart = 1'b1;
   logic            flip    = 1'b0;
   logic [3:0]      nbits   = 4'h8;
   logic [3:0][8:0] tx_w    = '0;
   logic [3:0][8:0] rx_w;
   logic [7:0]      n_lead, nl;
   logic [7:0]      run     = '0;
   logic [7:0]      hi_len  = '0;
   logic [31:0]     q, w0, w1;
   int              miscompares = 0;
   int              n_tests     = 0;
   // line levels from every party; clock line rests at idle
   wire dt_line = !dt_oe_n ? dt_out : (rem_en ? dt_bit : flip);
   wire ck_line = !ck_oe_n ? ck_out : (rem_ck ? rem_ckv : pol);

   ssm_top dut_u (
      .sys_clk(sys_clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
      .data_pin_in(dt_line), .data_pin_out(dt_out), .data_pin_oe_n(dt_oe_n),
      .shift_clock_pin_in(ck_line), .shift_clock_pin_out(ck_out),
      .shift_clock_pin_oe_n(ck_oe_n), .rx_irq(rx_irq));
   ssm_remote rem_u (
      .sys_clk(sys_clk), .restart(restart), .pol(pol), .nbits(nbits), .tx_w(tx_w),
      .ck_line(ck_line), .dt_line(dt_line), .dt_bit(dt_bit), .rx_w(rx_w),
      .n_lead(n_lead), .ck_drv(rem_ckv));

   always #4 sys_clk = ~sys_clk;
   // length of the last active clock phase
   always @(posedge sys_clk) begin
      flip <= ~flip;
      if (ck_out != pol)
         run <= run + 8'h01;
      else if (run != 8'h00) begin
         hi_len <= run;
         run    <= 8'h00;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic hang();
      miscompares++;
      end_of_test();
   endtask
   task automatic done(input int t);
      $display("test %0d finished", t);
   endtask
   // one APB transfer, held until pready is seen at an edge
   task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      req <= '{a, 1'b1, 1'b0, we, d};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         if (rsp.pready === 1'b1)
            break;
      end
      if (i == 16)
         hang();
      q = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // always reads afresh; a value left from an earlier transfer never counts
   task automatic poll(input logic [11:0] a, input int b, input logic v);
      int i;
      for (i = 0; i < 300; i++) begin
         rd(a);
         if (q[b] === v)
            break;
      end
      if (i == 300)
         hang();
   endtask
   task automatic wait_lead(input logic [7:0] n);
      int i;
      for (i = 0; i < 3000 && n_lead != n; i++)
         @(posedge sys_clk);
      if (i == 3000)
         hang();
      repeat (40) @(posedge sys_clk);
   endtask
   // receive enables cleared first; divisor 3
   task automatic setup(input logic [7:0] bc, input logic [7:0] tx, input logic [7:0] rx);
      pol <= bc[`SSM_B_POL];
      wr(`SSM_OFF_RXSTAT, 32'h0);
      wr(`SSM_OFF_DIVLO, 32'h3);
      wr(`SSM_OFF_BAUDCTL, {24'h0, bc});
      wr(`SSM_OFF_TXSTAT, {24'h0, tx});
      wr(`SSM_OFF_RXSTAT, {24'h0, rx});
      restart <= 1'b1;
      @(posedge sys_clk);
      restart <= 1'b0;
   endtask

   initial begin
      void'($urandom(19));
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      // reset values, read back, read-only bits, hole in the map
      for (int k = 0; k < 8; k++) begin
         rd(12'(4 * k));
         chk(q, (k == 5) ? 32'h2 : (k == 7) ? 32'h8 : 32'h0);
      end
      for (int k = 2; k < 4; k++) begin
         w0 = $urandom;
         wr(12'(4 * k), w0);
         rd(12'(4 * k));
         chk(q, {24'h0, w0[7:0]});
      end
      wr(`SSM_OFF_RXSTAT, 32'h3);
      rd(`SSM_OFF_RXSTAT);
      chk(q, 32'h0);
      rd(12'h020);
      chk({err, q[30:0]}, 32'h8000_0000);
      done(1);
      // master transmit back to back, both polarities and speeds
      for (int k = 0; k < 2; k++) begin
         nbits <= 4'h8 + 4'(k);
         setup(8'(k << 4), k ? 8'hf5 : 8'hb0, 8'h80);
         w0 = $urandom;
         w1 = $urandom;
         wr(`SSM_OFF_TXDATA, w0);
         wr(`SSM_OFF_TXDATA, w1);
         wait_lead(8'(2 * (8 + k)));
         chk(32'(rx_w[0]), {23'h0, k[0], w0[7:0]});
         chk(32'(rx_w[1]), {23'h0, k[0], w1[7:0]});
         chk(32'(hi_len), k ? 32'h4 : 32'h10);
         chk(32'({ck_out, ck_oe_n, dt_oe_n}), 32'({k[0], 2'b00}));
         done(2);
      end
      // single receive, eight and nine bits, interrupt off and on
      for (int k = 0; k < 2; k++) begin
         nbits <= 4'h8 + 4'(k);
         for (int j = 0; j < 4; j++) tx_w[j] <= 9'($urandom);
         setup(8'(k << 4), 8'h94, 8'(8'h80 | k << 6));
         wr(`SSM_OFF_INTCTL, 32'(k));
         rem_en <= 1'b1;
         wr(`SSM_OFF_RXSTAT, 32'(8'ha0 | k << 6));
         poll(`SSM_OFF_INTCTL, 2, 1'b1);
         repeat (150) @(posedge sys_clk);
         chk(32'(n_lead), 32'(8 + k));
         chk(32'({rx_irq, dt_oe_n}), 32'({k[0], 1'b1}));
         rd(`SSM_OFF_RXSTAT);
         chk(32'(q[5]), 32'h0);
         chk(32'(q[0]), 32'(k & tx_w[0][8]));
         rd(`SSM_OFF_RXDATA);
         chk(q, 32'(tx_w[0][7:0]));
         rd(`SSM_OFF_INTCTL);
         chk(32'(q[2]), 32'h0);
         rem_en <= 1'b0;
         done(3);
      end
      // continuous receive into a full fifo, cleared both ways
      for (int k = 0; k < 2; k++) begin
         nbits <= 4'h8;
         setup(8'h00, 8'h94, 8'h80);
         wr(`SSM_OFF_INTCTL, 32'h1);
         rem_en <= 1'b1;
         wr(`SSM_OFF_RXSTAT, 32'hb0);
         poll(`SSM_OFF_RXSTAT, 1, 1'b1);
         chk(32'(q[5:4]), 32'h1);
         for (int j = 0; j < 2; j++) begin
            rd(`SSM_OFF_RXDATA);
            chk(q, 32'(tx_w[j][7:0]));
         end
         repeat (300) @(posedge sys_clk);
         chk(32'(rx_irq), 32'h0);
         wr(`SSM_OFF_RXSTAT, k ? 32'h0 : 32'h80);
         rd(`SSM_OFF_RXSTAT);
         chk(32'(q[1]), 32'h0);
         rem_en <= 1'b0;
         done(4);
      end
      // three single receives with no read in between
      setup(8'h00, 8'h94, 8'h80);
      rem_en <= 1'b1;
      for (int j = 0; j < 3; j++) begin
         wr(`SSM_OFF_RXSTAT, 32'ha0);
         poll(`SSM_OFF_RXSTAT, 5, 1'b0);
      end
      chk(32'(q[1]), 32'h1);
      rd(`SSM_OFF_RXDATA);
      chk(q, 32'(tx_w[0][7:0]));
      rd(`SSM_OFF_RXSTAT);
      chk(32'(q[1]), 32'h0);
      done(5);
      // continuous receive cut off in mid character
      setup(8'h00, 8'h94, 8'h80);
      wr(`SSM_OFF_RXSTAT, 32'h90);
      repeat (30) @(posedge sys_clk);
      wr(`SSM_OFF_RXSTAT, 32'h80);
      repeat (4) @(posedge sys_clk);
      nl = n_lead;
      repeat (200) @(posedge sys_clk);
      chk(32'({n_lead, ck_out}), 32'({nl, pol}));
      rd(`SSM_OFF_INTCTL);
      chk(32'(q[2]), 32'h0);
      done(6);
      // slave receive on the remote's clock
      setup(8'h00, 8'h10, 8'h90);
      rem_ck <= 1'b1;
      @(posedge sys_clk);
      rem_u.clocks(8);
      poll(`SSM_OFF_INTCTL, 2, 1'b1);
      chk(32'(ck_oe_n), 32'h1);
      rd(`SSM_OFF_RXDATA);
      chk(q, 32'(tx_w[0][7:0]));
      done(7);
      end_of_test();
   end
endmodule
`default_nettype wire
